/* File: core/phy_regs_pkg.sv */
// Purpose: Shared constants and types for the PHY management register slice
// Assumes: 25 MHz system clock, APB with 32-bit data
// Notes: Register indices are word indices; byte address is four times the index
package phy_regs_pkg;
    // Clock and time base
    localparam int unsigned CLK_FREQ_HZ = 25_000_000;
    localparam int unsigned MS_PER_S = 1000;
    // Transmit pulse intervals, as printed
    localparam int unsigned TX_INT_00_S = 1;
    localparam int unsigned TX_INT_01_MS = 768;
    localparam int unsigned TX_INT_10_MS = 512;
    localparam int unsigned TX_INT_11_MS = 256;
    // Receive wake gap limits, as printed
    localparam int unsigned RX_GAP_00_MS = 64;
    localparam int unsigned RX_GAP_01_MS = 256;
    localparam int unsigned RX_GAP_10_MS = 512;
    localparam int unsigned RX_GAP_11_S = 1;
    // Bus widths
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int REG_W = 16;
    // Register indices
    localparam logic [5:0] IDX_BASIC_CTRL = 6'h00;
    localparam logic [5:0] IDX_RX_NEXT_PAGE = 6'h08;
    localparam logic [5:0] IDX_ACCESS_CTRL = 6'h0D;
    localparam logic [5:0] IDX_ADDR_DATA = 6'h0E;
    localparam logic [5:0] IDX_PD_CFG = 6'h10;
    localparam logic [5:0] IDX_MODE_CTRL = 6'h11;
    // Field positions
    localparam int SOFT_RST_BIT = 15;
    localparam int FUNC_LO = 14;
    localparam int TARGET_DEVICE_SELECT_W = 5;
    localparam int CFG_TX_EN = 15;
    localparam int CFG_TX_INT_LO = 13;
    localparam int CFG_SINGLE = 12;
    localparam int CFG_RX_INT_LO = 10;
    localparam int CFG_INDEP = 3;
    localparam int MODE_PD_EN = 13;
    localparam int MODE_PD_STATE = 1;
    // Manageable devices and their storage
    localparam logic [4:0] TARGET_DEVICE_SELECT_PCS = 5'h03;
    localparam logic [4:0] TARGET_DEVICE_SELECT_AN = 5'h07;
    localparam int MMD_IDX_W = 4;
    localparam int MMD_DEPTH = 16;
    // Reset values
    localparam logic [15:0] ADDR_DATA_RST = 16'h0000;
    localparam logic [1:0] FIELD2_RST = 2'h0;

    typedef enum logic [1:0] {
        FUNC_ADDRESS = 2'b00,
        FUNC_DATA = 2'b01,
        FUNC_RSVD_A = 2'b10,
        FUNC_RSVD_B = 2'b11
    } mmd_func_t;

    typedef enum logic {
        PD_ACTIVE = 1'b0,
        PD_SLEEP = 1'b1
    } pd_state_t;

    // Received page, laid out as the register reads
    typedef struct packed {
        logic next_page;
        logic ack;
        logic msg_page;
        logic ack2;
        logic toggle;
        logic [10:0] code;
    } np_page_t;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [ADDR_W-1:0] paddr;
        logic [DATA_W-1:0] pwdata;
    } apb_req_t;

    typedef struct packed {
        logic pready;
        logic pslverr;
        logic [DATA_W-1:0] prdata;
    } apb_rsp_t;

    // Byte address of a register index
    function automatic logic [ADDR_W-1:0] reg_addr(input logic [5:0] idx);
        return {idx, 2'b00};
    endfunction

    // Transmit pulse period in ms
    function automatic int unsigned tx_interval_ms(input logic [1:0] code);
        case (code)
            2'b00: return TX_INT_00_S * MS_PER_S;
            2'b01: return TX_INT_01_MS;
            2'b10: return TX_INT_10_MS;
            default: return TX_INT_11_MS;
        endcase
    endfunction

    // Longest gap between two wake pulses in ms
    function automatic int unsigned rx_gap_ms(input logic [1:0] code);
        case (code)
            2'b00: return RX_GAP_00_MS;
            2'b01: return RX_GAP_01_MS;
            2'b10: return RX_GAP_10_MS;
            default: return RX_GAP_11_S * MS_PER_S;
        endcase
    endfunction
endpackage

/* File: core/nlp_pulse_timer.sv */
// Purpose: Periodic link pulse generator
// Assumes: Period given in clock cycles, at least one
// Notes: First pulse comes one full period after run rises
module nlp_pulse_timer (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // Control
    input wire logic run,
    input wire logic [31:0] period_cyc,
    // Pulse out
    output logic pulse
);
    import phy_regs_pkg::*;

    logic [31:0] cnt_reg;
    logic [31:0] cnt_next;
    logic wrap;

    // Wrap when the period is used up
    assign wrap = (cnt_reg + 32'h1) >= period_cyc;
    assign cnt_next = wrap ? 32'h0 : cnt_reg + 32'h1;

    // Counter restarts whenever run drops, so no stale phase
    always_ff @(posedge clk_sys)
    begin
        if (rst || !run)
        begin
            cnt_reg <= 32'h0;
            pulse <= 1'b0;
        end
        else
        begin
            cnt_reg <= cnt_next;
            pulse <= wrap;
        end
    end
endmodule // nlp_pulse_timer

/* File: core/nlp_wake_detect.sv */
// Purpose: Wake detection from received link pulses
// Assumes: nlp_rx is a one-cycle pulse per received link pulse
// Notes: Gap limit is inclusive
module nlp_wake_detect (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // Control
    input wire logic armed,
    input wire logic single_mode,
    input wire logic [31:0] max_gap_cyc,
    // Line events
    input wire logic nlp_rx,
    output logic wake
);
    import phy_regs_pkg::*;

    logic seen_reg;
    logic [31:0] gap_reg;
    logic in_time;
    logic fire;

    // Second pulse counts only inside the gap limit
    assign in_time = gap_reg <= max_gap_cyc;
    assign fire = nlp_rx && (single_mode || (seen_reg && in_time));

    // Disarmed detector forgets any half-seen pair
    always_ff @(posedge clk_sys)
    begin
        if (rst || !armed)
        begin
            seen_reg <= 1'b0;
            gap_reg <= 32'h0;
            wake <= 1'b0;
        end
        else
        begin
            wake <= fire;
            if (nlp_rx)
            begin
                seen_reg <= !fire;
                gap_reg <= 32'h0;
            end
            else if (seen_reg)
            begin
                seen_reg <= in_time;
                gap_reg <= gap_reg + 32'h1;
            end
        end
    end
endmodule // nlp_wake_detect

/* File: core/phy_nextpage_mmd_energy_detect_powerdown_regs.sv */
// Purpose: PHY next-page view, indirect device access and power-down pulse control
// Assumes: APB slave, one wait-free access phase; line inputs synchronous to clk_sys
// Notes: CYCLES_PER_MS may be lowered in simulation to shorten pulse timing
module phy_nextpage_mmd_energy_detect_powerdown_regs #(
    parameter int unsigned CYCLES_PER_MS = phy_regs_pkg::CLK_FREQ_HZ / phy_regs_pkg::MS_PER_S
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // Register bus
    input wire phy_regs_pkg::apb_req_t apb_req,
    output phy_regs_pkg::apb_rsp_t apb_rsp,
    // Next page from the partner
    input wire logic np_rx_valid,
    input wire phy_regs_pkg::np_page_t np_rx_page,
    // Line side power-down
    input wire logic line_idle,
    input wire logic peer_port_asleep,
    input wire logic nlp_rx,
    output logic nlp_tx,
    output logic pd_asleep
);
    import phy_regs_pkg::*;

    // Register state
    np_page_t np_reg;
    mmd_func_t func_reg;
    logic [TARGET_DEVICE_SELECT_W-1:0] target_device_select_reg;
    logic [REG_W-1:0] mmd_addr_reg;
    logic [REG_W-1:0] mmd_mem [2][MMD_DEPTH];
    logic tx_en_reg;
    logic [1:0] tx_int_reg;
    logic single_reg;
    logic [1:0] rx_int_reg;
    logic indep_reg;
    logic pd_en_reg;
    logic wake_hold_reg;
    pd_state_t state_reg;
    pd_state_t state_next;
    apb_rsp_t rsp_next;

    // Bus decode
    logic setup;
    logic commit;
    logic wr;
    logic hit_basic;
    logic hit_np;
    logic hit_acc;
    logic hit_ad;
    logic hit_cfg;
    logic hit_mode;
    logic hit_any;
    logic [REG_W-1:0] wdata;
    logic soft_rst;

    assign setup = apb_req.psel && !apb_req.penable;
    assign commit = apb_req.psel && apb_req.penable && apb_rsp.pready;
    assign wr = commit && apb_req.pwrite;
    assign wdata = apb_req.pwdata[REG_W-1:0];
    assign hit_basic = apb_req.paddr == reg_addr(IDX_BASIC_CTRL);
    assign hit_np = apb_req.paddr == reg_addr(IDX_RX_NEXT_PAGE);
    assign hit_acc = apb_req.paddr == reg_addr(IDX_ACCESS_CTRL);
    assign hit_ad = apb_req.paddr == reg_addr(IDX_ADDR_DATA);
    assign hit_cfg = apb_req.paddr == reg_addr(IDX_PD_CFG);
    assign hit_mode = apb_req.paddr == reg_addr(IDX_MODE_CTRL);
    assign hit_any = hit_basic | hit_np | hit_acc | hit_ad | hit_cfg | hit_mode;
    assign soft_rst = wr && hit_basic && wdata[SOFT_RST_BIT];

    // Indirect access decode
    logic dev_known;
    logic dev_sel;
    logic word_ok;
    logic mode_addr;
    logic mode_data;
    logic [MMD_IDX_W-1:0] word_idx;
    logic [REG_W-1:0] mmd_word;

    assign dev_known = (target_device_select_reg == TARGET_DEVICE_SELECT_PCS) || (target_device_select_reg == TARGET_DEVICE_SELECT_AN);
    assign dev_sel = target_device_select_reg == TARGET_DEVICE_SELECT_AN;
    // Only the low words are backed; the rest read zero, ignore writes
    assign word_ok = mmd_addr_reg[REG_W-1:MMD_IDX_W] == '0;
    assign word_idx = mmd_addr_reg[MMD_IDX_W-1:0];
    assign mode_addr = func_reg == FUNC_ADDRESS;
    assign mode_data = func_reg == FUNC_DATA;
    assign mmd_word = (dev_known && word_ok) ? mmd_mem[dev_sel][word_idx] : '0;

    // Read value of each register, upper half zero
    logic [REG_W-1:0] rd_acc;
    logic [REG_W-1:0] rd_ad;
    logic [REG_W-1:0] rd_cfg;
    logic [REG_W-1:0] rd_mode;
    logic [REG_W-1:0] rd_val;

    assign rd_acc = {func_reg, {(REG_W - 2 - TARGET_DEVICE_SELECT_W){1'b0}}, target_device_select_reg};
    // Data mode reads the latched word
    assign rd_ad = mode_addr ? mmd_addr_reg : (mode_data ? mmd_word : '0);
    assign rd_cfg = {tx_en_reg, tx_int_reg, single_reg, rx_int_reg,
                     {(CFG_RX_INT_LO - CFG_INDEP - 1){1'b0}}, indep_reg,
                     {CFG_INDEP{1'b0}}};
    assign rd_mode = REG_W'((REG_W'(pd_en_reg) << MODE_PD_EN)
                     | (REG_W'(state_reg == PD_SLEEP) << MODE_PD_STATE));
    assign rd_val = hit_np ? np_reg
                  : hit_acc ? rd_acc
                  : hit_ad ? rd_ad
                  : hit_cfg ? rd_cfg
                  : hit_mode ? rd_mode
                  : '0;

    // Answer registered in setup, valid through the access phase
    assign rsp_next.pready = setup;
    assign rsp_next.pslverr = setup && !hit_any;
    assign rsp_next.prdata = (setup && !apb_req.pwrite) ? DATA_W'(rd_val) : '0;

    always_ff @(posedge clk_sys)
    begin
        if (rst)
            apb_rsp <= '0;
        else
            apb_rsp <= rsp_next;
    end

    // Received page capture
    // Whole page at once
    always_ff @(posedge clk_sys)
    begin
        if (rst)
            np_reg <= '0;
        else if (np_rx_valid)
            np_reg <= np_rx_page;
    end

    // Access control register
    // Function field write
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            func_reg <= FUNC_ADDRESS;
            target_device_select_reg <= '0;
        end
        else if (wr && hit_acc)
        begin
            func_reg <= mmd_func_t'(wdata[REG_W-1:FUNC_LO]);
            target_device_select_reg <= wdata[TARGET_DEVICE_SELECT_W-1:0];
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst)
            mmd_addr_reg <= ADDR_DATA_RST;
        else if (wr && hit_ad && mode_addr)
            mmd_addr_reg <= wdata;
    end

    // Device storage; reset keeps reads defined
    // Data write at latched address
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            for (int d = 0; d < 2; d++)
                for (int w = 0; w < MMD_DEPTH; w++)
                    mmd_mem[d][w] <= '0;
        end
        else if (wr && hit_ad && mode_data && dev_known && word_ok)
            mmd_mem[dev_sel][word_idx] <= wdata;
    end

    // Power-down configuration
    // Soft reset restores defaults
    always_ff @(posedge clk_sys)
    begin
        if (rst || soft_rst)
        begin
            tx_en_reg <= 1'b0;
            tx_int_reg <= FIELD2_RST;
            single_reg <= 1'b0;
            rx_int_reg <= FIELD2_RST;
            indep_reg <= 1'b0;
        end
        else if (wr && hit_cfg)
        begin
            tx_en_reg <= wdata[CFG_TX_EN];
            tx_int_reg <= wdata[CFG_TX_INT_LO+:2];
            single_reg <= wdata[CFG_SINGLE];
            rx_int_reg <= wdata[CFG_RX_INT_LO+:2];
            indep_reg <= wdata[CFG_INDEP];
        end
    end

    // Power-down mode enable; not tied to soft reset
    always_ff @(posedge clk_sys)
    begin
        if (rst)
            pd_en_reg <= 1'b0;
        else if (wr && hit_mode)
            pd_en_reg <= wdata[MODE_PD_EN];
    end

    // Pulse timing in cycles
    logic [31:0] tx_period_cyc;
    logic [31:0] rx_gap_cyc;
    logic wake;
    logic tx_run;
    logic asleep;

    assign tx_period_cyc = 32'(tx_interval_ms(tx_int_reg) * CYCLES_PER_MS);
    assign rx_gap_cyc = 32'(rx_gap_ms(rx_int_reg) * CYCLES_PER_MS);
    assign asleep = state_reg == PD_SLEEP;
    // Pulses only when enabled and asleep
    assign tx_run = tx_en_reg && pd_en_reg && asleep && (indep_reg || peer_port_asleep);

    // Sleep state: wake holds until the line shows energy, so no bounce back
    always_comb
    begin
        state_next = state_reg;
        case (state_reg)
            PD_ACTIVE:
                if (pd_en_reg && line_idle && !wake_hold_reg)
                    state_next = PD_SLEEP;
            PD_SLEEP:
                if (wake || !pd_en_reg)
                    state_next = PD_ACTIVE;
            default:
                state_next = PD_ACTIVE;
        endcase
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            state_reg <= PD_ACTIVE;
            wake_hold_reg <= 1'b0;
            pd_asleep <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
            wake_hold_reg <= wake || (wake_hold_reg && line_idle);
            pd_asleep <= state_next == PD_SLEEP;
        end
    end

    // Link pulse generator
    nlp_pulse_timer u_tx (
        .clk_sys(clk_sys),
        .rst(rst),
        .run(tx_run),
        .period_cyc(tx_period_cyc),
        .pulse(nlp_tx)
    );

    nlp_wake_detect u_wake (
        .clk_sys(clk_sys),
        .rst(rst),
        .armed(asleep),
        .single_mode(single_reg),
        .max_gap_cyc(rx_gap_cyc),
        .nlp_rx(nlp_rx),
        .wake(wake)
    );
endmodule // phy_nextpage_mmd_energy_detect_powerdown_regs

/* File: dv/phy_regs_props.sv */
// Purpose: Port-level assertions for the PHY register slice
// Assumes: One-cycle APB answer; shadow state follows completed bus writes
// Notes: Wake pair timing gets a few cycles of slack for the gap counter
module phy_regs_props #(
    parameter int unsigned CYCLES_PER_MS = 25000
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // Register bus
    input wire phy_regs_pkg::apb_req_t apb_req,
    input wire phy_regs_pkg::apb_rsp_t apb_rsp,
    // Line side
    input wire logic np_rx_valid,
    input wire phy_regs_pkg::np_page_t np_rx_page,
    input wire logic line_idle,
    input wire logic peer_port_asleep,
    input wire logic nlp_rx,
    input wire logic nlp_tx,
    input wire logic pd_asleep
);
    timeunit 1ns;
    timeprecision 1ns;
    import phy_regs_pkg::*;
    logic [15:0] pg_sh, cfg_sh, adr_sh;
    logic [1:0] fn_sh;
    logic [4:0] dv_sh;
    logic mode_en, tx_seen;
    logic [31:0] tx_gap, rx_gap;
    // Bus decode and timing limits from the shadow config
    wire [7:0] pa = apb_req.paddr;
    wire [15:0] wd = apb_req.pwdata[15:0];
    wire wr_hit = apb_req.psel && apb_req.penable && apb_rsp.pready && apb_req.pwrite;
    wire rd_hit = apb_rsp.pready && !apb_req.pwrite;
    wire [1:0] tc = cfg_sh[14:13];
    wire [1:0] gc = cfg_sh[11:10];
    wire [31:0] tx_cyc = CYCLES_PER_MS * (tc == 2'h0 ? 1000 : tc == 2'h1 ? 768 : tc == 2'h2 ? 512 : 256);
    wire [31:0] gap_cyc = CYCLES_PER_MS * (gc == 2'h0 ? 64 : gc == 2'h1 ? 256 : gc == 2'h2 ? 512 : 1000);
    wire tx_ok = pd_asleep && cfg_sh[15] && mode_en && (cfg_sh[3] || peer_port_asleep);
    // Shadow registers, updated at the completing edge like the design
    always_ff @(posedge clk_sys)
        if (rst)
            {pg_sh, cfg_sh, adr_sh, fn_sh, dv_sh, mode_en} <= '0;
        else
        begin
            if (np_rx_valid) pg_sh <= np_rx_page;
            if (wr_hit && pa == 8'h34) {fn_sh, dv_sh} <= {wd[15:14], wd[4:0]};
            if (wr_hit && pa == 8'h38 && fn_sh == 2'h0) adr_sh <= wd;
            if (wr_hit && pa == 8'h40) cfg_sh <= wd & 16'hFC08;
            if (wr_hit && pa == 8'h00 && wd[15]) cfg_sh <= '0;
            if (wr_hit && pa == 8'h44) mode_en <= wd[13];
        end
    // Pulse spacing counters; the receive one saturates
    always_ff @(posedge clk_sys)
        if (rst)
            {tx_gap, tx_seen, rx_gap} <= {32'h0, 1'b0, 32'hFFFFFFFF};
        else
        begin
            tx_gap <= nlp_tx ? 32'h0 : tx_gap + 32'h1;
            tx_seen <= tx_seen || nlp_tx;
            rx_gap <= nlp_rx ? 32'h0 : (&rx_gap ? rx_gap : rx_gap + 32'h1);
        end
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);
    a_page_view: assert property (rd_hit && pa == 8'h20 |-> apb_rsp.prdata == {16'h0000, pg_sh})
        else $error("page view differs from last page");
    a_ctrl_read: assert property (rd_hit && pa == 8'h34 |-> apb_rsp.prdata == {16'h0000, fn_sh, 9'h000, dv_sh})
        else $error("access control readback wrong");
    a_addr_read: assert property (rd_hit && pa == 8'h38 && fn_sh == 2'h0 |-> apb_rsp.prdata == {16'h0000, adr_sh})
        else $error("latched address readback wrong");
    a_rsvd_zero: assert property (rd_hit && pa == 8'h38 && fn_sh[1] |-> apb_rsp.prdata == 32'h0)
        else $error("reserved function read not zero");
    a_cfg_read: assert property (rd_hit && pa == 8'h40 |-> apb_rsp.prdata == {16'h0000, cfg_sh})
        else $error("config readback wrong");
    a_tx_cause: assert property (nlp_tx |-> $past(tx_ok))
        else $error("link pulse sent without cause");
    a_tx_spacing: assert property (nlp_tx && tx_seen |-> tx_gap + 32'h1 >= tx_cyc)
        else $error("link pulses too close");
    a_single_wake: assert property (pd_asleep && cfg_sh[12] && nlp_rx |-> ##[1:3] !pd_asleep)
        else $error("single pulse did not wake");
    a_pair_hold: assert property (pd_asleep && mode_en && !cfg_sh[12] && nlp_rx && rx_gap > gap_cyc + 4
        |=> pd_asleep [*3])
        else $error("woke on a pulse outside the gap");
    a_sleep_entry: assert property ($rose(pd_asleep) |-> $past(mode_en) && $past(line_idle))
        else $error("sleep entered without enable and idle line");
endmodule // phy_regs_props
bind phy_nextpage_mmd_energy_detect_powerdown_regs phy_regs_props #(.CYCLES_PER_MS(CYCLES_PER_MS)) phy_regs_props_inst (
    .clk_sys(clk_sys), .rst(rst), .apb_req(apb_req), .apb_rsp(apb_rsp), .np_rx_valid(np_rx_valid),
    .np_rx_page(np_rx_page), .line_idle(line_idle), .peer_port_asleep(peer_port_asleep), .nlp_rx(nlp_rx),
    .nlp_tx(nlp_tx), .pd_asleep(pd_asleep));

/* File: dv/link_partner_model.sv */
// Purpose: Far-side link partner sending pages and link pulses
// Assumes: The bench commands it through the tasks below
// Notes: Page lines wander between pages so stale data never looks valid
module link_partner_model (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // Line side
    output logic np_rx_valid,
    output phy_regs_pkg::np_page_t np_rx_page,
    output logic line_idle,
    output logic nlp_rx
);
    timeunit 1ns;
    timeprecision 1ns;
    import phy_regs_pkg::*;
    logic pg_req = 1'b0;
    logic pl_req = 1'b0;
    logic idle_req = 1'b0;
    np_page_t pg_next = '0;
    // Quiet lines at time zero
    initial
    begin
        np_rx_valid = 1'b0;
        np_rx_page = '0;
        nlp_rx = 1'b0;
        line_idle = 1'b0;
    end
    // Outputs move only just after the rising edge
    always @(posedge clk_sys)
    begin
        np_rx_valid <= pg_req && !rst;
        np_rx_page <= pg_req ? pg_next : ~np_rx_page;
        nlp_rx <= pl_req && !rst;
        line_idle <= idle_req;
    end
    // A whole page under one strobe
    task automatic send_page(input np_page_t p);
        @(negedge clk_sys);
        pg_next = p;
        pg_req = 1'b1;
        @(negedge clk_sys);
        pg_req = 1'b0;
    endtask
    // One link pulse, one cycle wide
    task automatic send_pulse;
        @(negedge clk_sys);
        pl_req = 1'b1;
        @(negedge clk_sys);
        pl_req = 1'b0;
    endtask
    task automatic set_idle(input logic b);
        @(negedge clk_sys);
        idle_req = b;
    endtask
endmodule // link_partner_model

/* File: dv/phy_nextpage_mmd_energy_detect_powerdown_regs_test.sv */
// Purpose: Register and line-side tests for the PHY register slice
// Assumes: Millisecond count lowered to 4 cycles
// Notes: Whole run is about 40k cycles
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin err_total++; $display("unexpected at %0t: %h not %h", $time, g, e); end end
module phy_nextpage_mmd_energy_detect_powerdown_regs_test;
    timeunit 1ns;
    timeprecision 1ns;
    import phy_regs_pkg::*;
    localparam int CPM = 4;
    localparam int TX_MS[4] = '{1000, 768, 512, 256};
    localparam int RX_MS[4] = '{64, 256, 512, 1000};
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic peer_port_asleep = 1'b0;
    apb_req_t req = '0;
    apb_rsp_t rsp;
    np_page_t np_rx_page;
    logic np_rx_valid, line_idle, nlp_rx, nlp_tx, pd_asleep, last_err;
    int err_total = 0;
    int cmp_count = 0;
    always #20 clk_sys = ~clk_sys;
    phy_nextpage_mmd_energy_detect_powerdown_regs #(.CYCLES_PER_MS(CPM)) phy_nextpage_mmd_energy_detect_powerdown_regs_inst (.clk_sys(clk_sys), .rst(rst),
        .apb_req(req), .apb_rsp(rsp), .np_rx_valid(np_rx_valid), .np_rx_page(np_rx_page), .line_idle(line_idle),
        .peer_port_asleep(peer_port_asleep), .nlp_rx(nlp_rx), .nlp_tx(nlp_tx), .pd_asleep(pd_asleep));
    link_partner_model link_partner_model_inst (.clk_sys(clk_sys), .rst(rst), .np_rx_valid(np_rx_valid),
        .np_rx_page(np_rx_page), .line_idle(line_idle), .nlp_rx(nlp_rx));
    task automatic complete_run;
        if (err_total == 0 && cmp_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // One APB transfer; the request stands until pready is seen
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [15:0] d, output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clk_sys);
        req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: {16'h0000, d}};
        @(posedge clk_sys);
        req.penable <= 1'b1;
        do
        begin
            @(posedge clk_sys);
            n++;
        end
        while (rsp.pready !== 1'b1 && n < 20);
        q = rsp.prdata;
        last_err = rsp.pslverr;
        req.psel <= 1'b0;
        req.penable <= 1'b0;
        if (n >= 20) err_total++;
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        logic [31:0] q;
        xfer(1'b1, a, d, q);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] q;
        xfer(1'b0, a, 16'h0000, q);
        `CHK(q, e)
    endtask
    // Line-side waits, all bounded
    task automatic ticks(input int n);
        repeat (n) @(posedge clk_sys);
    endtask
    task automatic wait_sleep;
        int n;
        n = 0;
        while (pd_asleep !== 1'b1 && n < 50)
        begin
            @(posedge clk_sys);
            n++;
        end
        `CHK(pd_asleep, 1'b1)
    endtask
    task automatic next_tx(output int n);
        n = 0;
        do
            @(posedge clk_sys);
        while (nlp_tx !== 1'b1 && ++n < 9000);
        n++;
    endtask
    task automatic count_tx(input int span, output int c);
        c = 0;
        repeat (span)
        begin
            @(posedge clk_sys);
            if (nlp_tx === 1'b1) c++;
        end
    endtask
    // Watchdog, about twice the expected run
    initial
    begin
        #(40 * 90000);
        err_total++;
        complete_run();
    end
    // Main sequence
    initial
    begin
        int n;
        logic [15:0] pages[7] = '{16'h8000, 16'h4000, 16'h2000, 16'h1000, 16'h0800, 16'h07FF, 16'hA5A5};
        logic [4:0] devs[2] = '{5'h03, 5'h07};
        ticks(16);
        rst <= 1'b0;
        rd(8'h34, 32'h0);
        rd(8'h38, 32'h0);
        rd(8'h3C, 32'h0);
        `CHK(last_err, 1'b1)
        foreach (pages[i])
        begin
            link_partner_model_inst.send_page(pages[i]);
            wr(8'h20, ~pages[i]);
            rd(8'h20, {16'h0000, pages[i]});
        end
        // Address then data for each device, then reserved codes
        foreach (devs[i])
        begin
            wr(8'h34, {11'h000, devs[i]});
            rd(8'h34, {27'h0, devs[i]});
            wr(8'h38, 16'h0005);
            rd(8'h38, 32'h5);
            wr(8'h34, {11'h200, devs[i]});
            rd(8'h34, {16'h0000, 11'h200, devs[i]});
            wr(8'h38, {11'h606, devs[i]});
            rd(8'h38, {16'h0000, 11'h606, devs[i]});
            for (int f = 2; f < 4; f++)
            begin
                wr(8'h34, {f[1:0], 9'h000, devs[i]});
                wr(8'h38, 16'h1234);
                rd(8'h38, 32'h0);
            end
        end
        wr(8'h34, 16'h0003);
        rd(8'h38, 32'h5);
        wr(8'h34, 16'h4003);
        rd(8'h38, {16'h0000, 11'h606, 5'h03});
        wr(8'h40, 16'hFFFF);
        rd(8'h40, 32'hFC08);
        wr(8'h00, 16'h8000);
        rd(8'h40, 32'h0);
        // Transmit period for every interval code
        link_partner_model_inst.set_idle(1'b1);
        for (int c = 0; c < 4; c++)
        begin
            wr(8'h44, 16'h0000);
            // independent mode set with transmit enable
            wr(8'h40, {1'b1, c[1:0], 9'h000, 1'b1, 3'h0});
            wr(8'h44, 16'h2000);
            wait_sleep();
            next_tx(n);
            next_tx(n);
            `CHK(n, TX_MS[c] * CPM)
        end
        wr(8'h44, 16'h0000);
        wr(8'h40, 16'hE000);
        count_tx(1100, n);
        `CHK(n, 0)
        wr(8'h44, 16'h2000);
        wait_sleep();
        rd(8'h44, 32'h2002);
        count_tx(1100, n);
        `CHK(n, 0)
        peer_port_asleep <= 1'b1;
        next_tx(n);
        next_tx(n);
        `CHK(n, 256 * CPM)
        // Wake on one pulse, then stay asleep on a pair just outside the gap and wake on a pair inside it
        wr(8'h40, 16'h1000);
        link_partner_model_inst.send_pulse();
        ticks(4);
        `CHK(pd_asleep, 1'b0)
        for (int g = 0; g < 4; g++)
        begin
            link_partner_model_inst.set_idle(1'b0);
            ticks(2);
            link_partner_model_inst.set_idle(1'b1);
            wait_sleep();
            wr(8'h40, {4'h0, g[1:0], 10'h000});
            link_partner_model_inst.send_pulse();
            ticks(RX_MS[g] * CPM + 20);
            link_partner_model_inst.send_pulse();
            ticks(4);
            `CHK(pd_asleep, 1'b1)
            ticks(RX_MS[g] * CPM - 20);
            link_partner_model_inst.send_pulse();
            ticks(4);
            `CHK(pd_asleep, 1'b0)
        end
        complete_run();
    end
endmodule // phy_nextpage_mmd_energy_detect_powerdown_regs_test
